// ===== src/nested_interrupt_controller.sv
`timescale 1ns/100ps
// Behaviour
// - Mask bits 7..4 gate second timer, first timer, serial rx, serial tx.
// - Mask bits 3..0 gate sampling modulator, stream input, control port, converter.
// - Enable mask write takes effect within six cycles.
// - Any global-disable write adds one to the nesting depth, which holds at 31.
// - Global-disable write takes effect within six cycles.
// - Global-enable write subtracts one, never below zero.
// - At depth zero the enabled sources may interrupt again.
// - Each interrupt taken by the core adds one to depth.
// - Global-enable write takes effect within six cycles.
// - Depth is readable; nonzero means all source interrupts disabled (evt_irq is not gated by depth).
`include "nic_map.svh"

module nested_interrupt_controller
  import nic_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  src_req,
  output logic             core_irq,
  output logic [2:0]       core_vector,
  input  wire logic        core_ack,
  output logic             evt_irq
);

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  function automatic logic hit(input logic [31:0] addr,
                               input logic [15:0] idx);
    hit = (addr[31:2] == {14'h0000, idx}) && (addr[1:0] == 2'h0);
  endfunction

  function automatic logic mapped(input logic [31:0] addr);
    mapped = hit(addr, `IDX_ENABLE_MASK) || hit(addr, `IDX_GLOBAL_DIS) ||
             hit(addr, `IDX_GLOBAL_ENA) || hit(addr, `IDX_DEPTH_COUNTER) ||
             hit(addr, `IDX_EVT_STATUS) || hit(addr, `IDX_EVT_MASK);
  endfunction

  // Highest source bit wins, so the second timer has top priority
  function automatic logic [2:0] top_bit(input logic [7:0] v);
    top_bit = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) begin
        top_bit = 3'(i);
      end
    end
  endfunction

  // -----------------------------------------------------------------
  // Reset release
  // -----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_q_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_q_n = rst_sync[1];

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  ctl_state_s st_reg;
  ctl_state_s st_next;

  logic       wr_fire;
  logic       ar_fire;
  logic       take;
  logic       wr_mask;
  logic       wr_dis;
  logic       wr_ena;
  logic       wr_depth;
  logic [7:0] clr_mask;
  logic [5:0] sum;
  logic [2:0] evt_set;

  assign s_axi_awready = !st_reg.aw_held && !st_reg.bvalid;
  assign s_axi_wready  = !st_reg.w_held && !st_reg.bvalid;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;
  assign core_irq      = st_reg.irq;
  assign core_vector   = st_reg.vector;
  assign evt_irq       = st_reg.evt_irq;

  // Commit once both halves of a write are held
  assign wr_fire  = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
  assign ar_fire  = s_axi_arvalid && s_axi_arready;
  assign wr_mask  = wr_fire && hit(st_reg.aw_addr, `IDX_ENABLE_MASK) && st_reg.w_strb[0];
  assign wr_dis   = wr_fire && hit(st_reg.aw_addr, `IDX_GLOBAL_DIS);
  assign wr_ena   = wr_fire && hit(st_reg.aw_addr, `IDX_GLOBAL_ENA);
  assign wr_depth = wr_fire && hit(st_reg.aw_addr, `IDX_DEPTH_COUNTER) && st_reg.w_strb[0];
  // Core takes the interrupt it is shown this cycle
  assign take     = core_ack && st_reg.irq;
  assign clr_mask = take ? (8'h01 << st_reg.vector) : 8'h00;

  always_comb begin
    st_next = st_reg;
    evt_set = 3'h0;
    sum     = {1'b0, st_reg.depth};

    // ---------------------------------------------------------------
    // Bus write channels
    // ---------------------------------------------------------------
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      st_next.aw_held = 1'b0;
      st_next.w_held  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = mapped(st_reg.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // ---------------------------------------------------------------
    // Enable mask and event mask
    // ---------------------------------------------------------------
    // mask lands next edge
    if (wr_mask) begin
      st_next.enable_mask = st_reg.w_data[7:0];
    end
    if (wr_fire && hit(st_reg.aw_addr, `IDX_EVT_MASK) && st_reg.w_strb[0]) begin
      st_next.evt_mask = st_reg.w_data[2:0];
    end

    // ---------------------------------------------------------------
    // Nesting depth
    // ---------------------------------------------------------------
    // disable strobe adds one
    sum = sum + {5'h00, wr_dis} + {5'h00, take};
    if (wr_ena) begin
      if (sum != 6'h00) begin
        sum = sum - 6'h01;
      end else begin
        evt_set[`EVT_UNDERFLOW] = 1'b1;
      end
    end
    // Saturate rather than wrap, or nesting would silently reopen
    if (sum > {1'b0, `DEPTH_MAX}) begin
      sum = {1'b0, `DEPTH_MAX};
      evt_set[`EVT_SATURATED] = 1'b1;
    end
    st_next.depth = sum[4:0];
    if (wr_depth) begin
      st_next.depth = st_reg.w_data[4:0];
    end
    evt_set[`EVT_TAKEN] = take;

    // ---------------------------------------------------------------
    // Pending requests and forwarding
    // ---------------------------------------------------------------
    // held until taken, new request wins
    st_next.pending = (st_reg.pending & ~clr_mask) | src_req;
    st_next.irq    = (st_next.depth == 5'h00) &&
                     ((st_next.pending & st_next.enable_mask) != 8'h00);
    st_next.vector = top_bit(st_next.pending & st_next.enable_mask);

    // ---------------------------------------------------------------
    // Bus read channel
    // ---------------------------------------------------------------
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (ar_fire) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      st_next.rdata  = 32'h0;
      if (hit(s_axi_araddr, `IDX_ENABLE_MASK)) begin
        st_next.rdata = {24'h0, st_reg.enable_mask};
      end
      if (hit(s_axi_araddr, `IDX_DEPTH_COUNTER)) begin
        st_next.rdata = {27'h0, st_reg.depth};
      end
      if (hit(s_axi_araddr, `IDX_EVT_MASK)) begin
        st_next.rdata = {29'h0, st_reg.evt_mask};
      end
      if (hit(s_axi_araddr, `IDX_EVT_STATUS)) begin
        st_next.rdata      = {29'h0, st_reg.evt_status};
        st_next.evt_status = 3'h0;
      end
    end

    // Set after clear so a same-cycle event survives the read
    st_next.evt_status = st_next.evt_status | evt_set;
    st_next.evt_irq    = (st_next.evt_status & st_next.evt_mask) != 3'h0;
  end

  always_ff @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      st_reg             <= '0;
      st_reg.enable_mask <= `RST_ENABLE_MASK;
      st_reg.depth       <= `RST_DEPTH;
      st_reg.evt_status  <= `RST_EVT;
      st_reg.evt_mask    <= `RST_EVT;
    end else begin
      st_reg <= st_next;
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_q_n);

  logic [4:0] depth_d;
  always_ff @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      depth_d <= 5'h00;
    end else begin
      depth_d <= st_reg.depth;
    end
  end

  mask_write_a: assert property (
    wr_mask |-> ##[1:6] st_reg.enable_mask == $past(st_reg.w_data[7:0], 1))
    else $error("enable mask write not applied");

  disable_inc_a: assert property (
    wr_dis && !take && st_reg.depth != `DEPTH_MAX
      |=> st_reg.depth == depth_d + 5'h01)
    else $error("disable strobe did not add one");

  disable_latency_a: assert property (
    wr_dis && !take && st_reg.depth == 5'h00 |-> ##[1:6] st_reg.depth != 5'h00)
    else $error("disable strobe late");

  enable_dec_a: assert property (
    wr_ena && !take && st_reg.depth != 5'h00 |=> st_reg.depth == depth_d - 5'h01)
    else $error("enable strobe did not subtract one");

  enable_floor_a: assert property (
    wr_ena && !take && st_reg.depth == 5'h00 |=> st_reg.depth == 5'h00 && st_reg.evt_status[`EVT_UNDERFLOW])
    else $error("enable strobe went below zero");

  enable_latency_a: assert property (
    wr_ena && !take && st_reg.depth == 5'h01 |-> ##[1:6] st_reg.depth == 5'h00)
    else $error("enable strobe late");

  reopen_a: assert property (
    st_reg.depth == 5'h00 && !take && !wr_fire && (st_reg.pending & st_reg.enable_mask) != 8'h00
      |=> core_irq)
    else $error("enabled source not forwarded at depth zero");

  take_inc_a: assert property (
    take && !wr_fire |=> st_reg.depth == 5'h01 && st_reg.evt_status[`EVT_TAKEN])
    else $error("taken interrupt did not add one");

  gate_a: assert property (
    core_irq |-> st_reg.depth == 5'h00 && st_reg.enable_mask[core_vector] && st_reg.pending[core_vector])
    else $error("request forwarded while gated");

  depth_read_a: assert property (
    ar_fire && hit(s_axi_araddr, `IDX_DEPTH_COUNTER) |=> s_axi_rvalid && s_axi_rdata[4:0] == depth_d)
    else $error("depth read wrong");

  // Second timer outranks every other enabled source
  second_timer_a: assert property (
    st_reg.depth == 5'h00 && !take && !wr_fire &&
      st_reg.enable_mask[`BIT_SECOND_TIMER] && st_reg.pending[`BIT_SECOND_TIMER]
      |=> core_irq && core_vector == 3'(`BIT_SECOND_TIMER))
    else $error("second timer not forwarded first");

  first_timer_a: assert property (
    st_reg.depth == 5'h00 && !take && !wr_fire && st_reg.pending == 8'h40 && src_req == 8'h00 &&
      st_reg.enable_mask[`BIT_FIRST_TIMER] |=> core_irq && core_vector == 3'(`BIT_FIRST_TIMER))
    else $error("first timer not forwarded");

  low_nibble_a: assert property (
    core_irq && (st_reg.pending & st_reg.enable_mask & 8'hf0) == 8'h00
      |-> core_vector <= 3'(`BIT_SAMPLING_MOD))
    else $error("low nibble source misrouted");

  saturate_a: assert property (
    wr_dis && st_reg.depth == `DEPTH_MAX
      |=> st_reg.depth == `DEPTH_MAX && st_reg.evt_status[`EVT_SATURATED])
    else $error("depth wrapped past its top");

  // Level sources re-set pending on every high cycle
  pending_set_a: assert property (
    src_req != 8'h00 |=> (st_reg.pending & $past(src_req, 1)) == $past(src_req, 1))
    else $error("request not held pending");

  depth_block_a: assert property (
    st_reg.depth != 5'h00 |-> !core_irq)
    else $error("interrupt forwarded at nonzero depth");

  take_clear_a: assert property (
    take && !src_req[core_vector] |=> !st_reg.pending[$past(core_vector, 1)])
    else $error("taken request still pending");

  event_irq_a: assert property (
    evt_irq == ((st_reg.evt_status & st_reg.evt_mask) != 3'h0))
    else $error("event interrupt out of step");

endmodule

// ===== src/nic_map.svh
`ifndef NIC_MAP_SVH
`define NIC_MAP_SVH

// -----------------------------------------------------------------
// Register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define IDX_ENABLE_MASK   16'hc01a
`define IDX_GLOBAL_DIS    16'hc01b
`define IDX_GLOBAL_ENA    16'hc01c
`define IDX_DEPTH_COUNTER 16'hc01d
`define IDX_EVT_STATUS    16'hc040
`define IDX_EVT_MASK      16'hc041

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define RST_ENABLE_MASK   8'h00
`define RST_DEPTH         5'h00
`define RST_EVT           3'h0

// -----------------------------------------------------------------
// Source bit positions in the enable mask
// -----------------------------------------------------------------
`define BIT_SECOND_TIMER  7
`define BIT_FIRST_TIMER   6
`define BIT_SERIAL_RX     5
`define BIT_SERIAL_TX     4
`define BIT_SAMPLING_MOD  3
`define BIT_STREAM_INPUT  2
`define BIT_CONTROL_PORT  1
`define BIT_AUDIO_CONV    0

// -----------------------------------------------------------------
// Event status bits, depth limits, bus answers
// -----------------------------------------------------------------
`define EVT_TAKEN         0
`define EVT_UNDERFLOW     1
`define EVT_SATURATED     2
`define DEPTH_MAX         5'h1f
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ===== src/nic_pkg.sv
package nic_pkg;

  // -----------------------------------------------------------------
  // Whole controller state
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  enable_mask;
    logic [4:0]  depth;
    logic [7:0]  pending;
    logic        irq;
    logic [2:0]  vector;
    logic [2:0]  evt_status;
    logic [2:0]  evt_mask;
    logic        evt_irq;
    logic        aw_held;
    logic [31:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ctl_state_s;

endpackage

// ===== tb/core_model.sv
`timescale 1ns/100ps
// ---------------------------------------------
// Core and peripheral stand-in
// ---------------------------------------------
module core_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       core_irq,
  input  wire logic [2:0] core_vector,
  input  wire logic [7:0] req_in,
  input  wire logic       slow,
  output logic [7:0]      src_req,
  output logic            core_ack,
  output logic [2:0]      last_vec
);
  logic [1:0] wait_cnt;

  // Slow mode lets the request stand a few cycles before the core takes it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_req  <= 8'h00;
      core_ack <= 1'b0;
      last_vec <= 3'h0;
      wait_cnt <= 2'h0;
    end else begin
      src_req  <= req_in;
      core_ack <= 1'b0;
      if (core_irq && !core_ack) begin
        if (!slow || wait_cnt == 2'h2) begin
          core_ack <= 1'b1;
          last_vec <= core_vector;
          wait_cnt <= 2'h0;
        end else begin
          wait_cnt <= wait_cnt + 2'h1;
        end
      end
    end
  end
endmodule

// ===== tb/tb.sv
`timescale 1ns/100ps
`include "nic_map.svh"
module tb;
  // ---------------------------------------------
  // Signals and constants
  // ---------------------------------------------
  localparam logic [31:0] a_mask  = 4 * `IDX_ENABLE_MASK;
  localparam logic [31:0] a_dis   = 4 * `IDX_GLOBAL_DIS;
  localparam logic [31:0] a_ena   = 4 * `IDX_GLOBAL_ENA;
  localparam logic [31:0] a_depth = 4 * `IDX_DEPTH_COUNTER;
  localparam logic [31:0] a_stat  = 4 * `IDX_EVT_STATUS;
  localparam logic [31:0] a_emask = 4 * `IDX_EVT_MASK;
  logic        clk = 0, rst_n = 0, slow = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [3:0]  wstrb = 0;
  logic [7:0]  req = 0;
  wire         awready, wready, bvalid, arready, rvalid, core_irq, core_ack, evt_irq;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [2:0]  core_vector, last_vec;
  wire  [7:0]  src_req;
  int          error_cnt = 0, checks_done = 0;
  // Rows: enable mask, request, expected vector (8 means no interrupt)
  logic [19:0] rows [9] = '{20'h80807, 20'h40406, 20'h20205, 20'h10104, 20'h08083,
                            20'h04042, 20'h02021, 20'h01010, 20'h0ff08};

  always #2 clk = ~clk;

  nested_interrupt_controller i_dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .src_req(src_req), .core_irq(core_irq), .core_vector(core_vector), .core_ack(core_ack),
    .evt_irq(evt_irq));

  core_model i_core (.clk(clk), .rst_n(rst_n), .core_irq(core_irq), .core_vector(core_vector),
    .req_in(req), .slow(slow), .src_req(src_req), .core_ack(core_ack), .last_vec(last_vec));

  // ---------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // Ready is sampled at the falling edge so the taking edge is known in advance
  task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
    logic ta, tw, da, dw;
    ta = 0;
    tw = 0;
    @(posedge clk);
    awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!(ta && tw)) begin
      @(negedge clk);
      da = awvalid && awready;
      dw = wvalid && wready;
      @(posedge clk);
      if (da) begin awvalid <= 0; ta = 1; end
      if (dw) begin wvalid <= 0; tw = 1; end
    end
    do @(negedge clk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge clk);
    bready <= 0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 0;
    do @(negedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 0;
  endtask

  task automatic rdc(input string n, input logic [31:0] a, e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(n, e, d);
    chk("rresp", `RESP_OKAY, r);
  endtask

  task automatic wrc(input logic [31:0] a, d);
    logic [1:0] r;
    wr(a, d, r);
    chk("bresp", `RESP_OKAY, r);
  endtask

  task automatic pulse(input logic [7:0] v);
    @(posedge clk);
    req <= v;
    @(posedge clk);
    req <= 0;
  endtask

  task automatic watch(output logic s);
    s = 0;
    repeat (8) begin @(negedge clk); if (core_irq === 1'b1) s = 1; end
  endtask

  task automatic summarize;
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ---------------------------------------------
  // Sequence
  // ---------------------------------------------
  initial begin
    logic [19:0] row;
    logic        s;
    logic [31:0] d;
    logic [1:0]  r;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    wrc(a_emask, 32'h7);
    for (int i = 0; i < 9; i++) begin
      row = rows[i];
      wrc(a_mask, {24'h0, row[19:12]});
      pulse(row[11:4]);
      watch(s);
      chk("irq_seen", row[3:0] != 4'h8, s);
      if (row[3:0] != 4'h8) chk("vector", row[3:0], last_vec);
      rdc("depth", a_depth, row[3:0] != 4'h8);
      wrc(a_ena, 32'h0);
      rdc("depth", a_depth, 0);
    end
    rd(a_stat, d, r);
    slow <= 1;
    wrc(a_dis, 32'hffff);
    wrc(a_dis, 32'h0);
    rdc("depth", a_depth, 2);
    wrc(a_mask, 32'h4);
    pulse(8'h04);
    watch(s);
    chk("irq_nested", 0, s);
    wrc(a_ena, 32'h0);
    watch(s);
    chk("irq_nested", 0, s);
    wrc(a_ena, 32'h0);
    watch(s);
    chk("irq_restored", 1, s);
    rdc("depth", a_depth, 1);
    wrc(a_ena, 32'h0);
    wrc(a_ena, 32'h0);
    rdc("depth", a_depth, 0);
    @(negedge clk);
    chk("evt_irq", 1, evt_irq);
    rdc("evt_status", a_stat, 3);
    rdc("evt_status", a_stat, 0);
    @(negedge clk);
    chk("evt_irq", 0, evt_irq);
    wrc(a_depth, 32'h1f);
    wrc(a_dis, 32'h0);
    rdc("depth_sat", a_depth, 32'h1f);
    rdc("evt_sat", a_stat, 32'h4);
    wrc(a_depth, 32'h5);
    rdc("depth", a_depth, 5);
    wr(32'h30108, 0, r);
    chk("bresp_unmapped", `RESP_SLVERR, r);
    wr(32'h3006a, 0, r);
    chk("bresp_misaligned", `RESP_SLVERR, r);
    rd(32'h30108, d, r);
    chk("rresp_unmapped", `RESP_SLVERR, r);
    chk("rdata_unmapped", 0, d);
    rdc("strobe_read", a_dis, 0);
    // Second reset in mid-run
    @(posedge clk);
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    rdc("mask_rst", a_mask, 0);
    rdc("depth_rst", a_depth, 0);
    summarize;
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    summarize;
  end
endmodule
